// file: core/priority_pin_crossbar.v
// priority pin crossbar: routes on-chip peripheral signals onto 24 port pins
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "pin_crossbar_consts.vh"

// Function
// R01: enabled functions walk in fixed priority from UART, each after UART taking lowest free pin
// R02: a pin already given to a function is passed over by later functions
// R03: pins with bypass mask bit set count as occupied and are skipped
// R04: one bypass bit per pin; port0 mask 0x44 skips pins 2 and 6
// R05: enabled UART always sits on port0 pin4 (tx) and pin5 (rx)
// R06: twowire claims data and clock together; UART claims tx and rx together
// R07: SPI claims three pins, four with slave select in 4-wire mode
// R08: unclaimed pins remain general purpose port pins
// R09: writing 1 to the global enable bit activates routing
// R10: crossbar off means every pin is a general purpose input
// R11: all output drivers are off while the crossbar is disabled
// R12: input kind bit 1 digital, 0 analog; reset gives digital everywhere
// R13: analog pins lose pull-up, output driver and input receiver
// R14: drive kind bit picks open-drain or push-pull; twowire pins forced open-drain
// R15: pullup_kill 0 enables weak pull-up on digital open-drain pins only
// R16: weak pull-up off on a pin driving low
// R17: software should bypass pins used by peripherals outside the crossbar
// R18: software sets input kind, drive kind, bypass, enables, then global enable
// R19: first routing register bits 7:6 read zero and ignore writes
// R20: first routing register bit 5 routes asynchronous comparator output
// R21: bit 4 routes synchronous comparator output, bit 3 the system clock
// R22: bits 2,1,0 route twowire, SPI and UART
// R23: second register bit 7 kills pull-ups, bit 6 is global enable
// R24: two-bit array field routes none, out0, out0-1, out0-2
// R25: second register bits 5,4,3 route timer b, timer a, array clock input
// R26: assignment recomputes at once whenever enables, bypass or SPI mode change
module priority_pin_crossbar
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // port latch values and pad levels
    input  wire [23:0] port_out_i,
    input  wire [23:0] pad_in_i,
    output wire [23:0] port_in_o,
    // peripheral signals to and from the pins, in slot order
    input  wire [16:0] func_out_i,
    input  wire [16:0] func_oe_i,
    output wire [16:0] func_in_o,
    // pad controls; drive enable is active low
    output wire [23:0] pad_out_o,
    output wire [23:0] pad_oe_n_o,
    output wire [23:0] pad_pullup_o,
    output wire [23:0] pad_digital_o
);

    // register selects, decoded once for the write path; the read path decodes addr_i again in its own case
    wire        sel_ctl0_w   = (addr_i == `XB_ADDR_CTL0);
    wire        sel_ctl1_w   = (addr_i == `XB_ADDR_CTL1);
    wire        sel_ssmode_w = (addr_i == `XB_ADDR_SSMODE);
    wire [2:0]  sel_byp_w    = {addr_i == `XB_ADDR_BYP2,
                                addr_i == `XB_ADDR_BYP1,
                                addr_i == `XB_ADDR_BYP0};
    wire [2:0]  sel_kind_w   = {addr_i == `XB_ADDR_KIND2,
                                addr_i == `XB_ADDR_KIND1,
                                addr_i == `XB_ADDR_KIND0};
    wire [2:0]  sel_drv_w    = {addr_i == `XB_ADDR_DRV2,
                                addr_i == `XB_ADDR_DRV1,
                                addr_i == `XB_ADDR_DRV0};

    reg  [7:0]  ctl0_q;
    reg  [7:0]  ctl1_q;
    reg  [1:0]  ssmode_q;
    wire [23:0] byp_q;
    wire [23:0] kind_q;
    wire [23:0] drv_q;

    // unused bits are masked on the way in, so readback needs no second mask
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctl0_q <= `XB_CTL0_RESET;
        else if (wr_i && sel_ctl0_w)
            ctl0_q <= wdata_i & `XB_CTL0_MASK; // R19
    end

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctl1_q <= `XB_CTL1_RESET;
        else if (wr_i && sel_ctl1_w)
            ctl1_q <= wdata_i & `XB_CTL1_MASK; // R09
    end

    // only bit 1 steers placement; bit 0 is kept so software reads back what it wrote
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ssmode_q <= `XB_SSMODE_RESET;
        else if (wr_i && sel_ssmode_w)
            ssmode_q <= wdata_i[1:0];
    end

    // per-pin settings, one byte of each per port
    genvar n;
    generate
        for (n = 0; n < 3; n = n + 1)
        begin : g_port
            reg [7:0] byp_b_q;
            reg [7:0] kind_b_q;
            reg [7:0] drv_b_q;
            always @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    byp_b_q  <= `XB_BYP_RESET;
                    kind_b_q <= `XB_KIND_RESET; // R12
                    drv_b_q  <= `XB_DRV_RESET;
                end
                else if (wr_i)
                begin
                    if (sel_byp_w[n])
                        byp_b_q <= wdata_i; // R04
                    if (sel_kind_w[n])
                        kind_b_q <= wdata_i;
                    if (sel_drv_w[n])
                        drv_b_q <= wdata_i;
                end
            end
            assign byp_q[8*n +: 8]  = byp_b_q;
            assign kind_q[8*n +: 8] = kind_b_q;
            assign drv_q[8*n +: 8]  = drv_b_q;
        end
    endgenerate

    // placement result: a five-bit pin number per slot, all ones when the slot has no pin
    wire [5*`XB_NFUNC-1:0] slot_pin_w;

    // readback byte; zero on idle cycles and unmapped addresses
    reg  [7:0]  rdata_d;
    always @*
    begin
        rdata_d = 8'h_00;
        if (rd_i)
        begin
            case (addr_i)
                `XB_ADDR_CTL0:   rdata_d = ctl0_q;
                `XB_ADDR_CTL1:   rdata_d = ctl1_q;
                `XB_ADDR_BYP0:   rdata_d = byp_q[7:0];
                `XB_ADDR_BYP1:   rdata_d = byp_q[15:8];
                `XB_ADDR_BYP2:   rdata_d = byp_q[23:16];
                `XB_ADDR_KIND0:  rdata_d = kind_q[7:0];
                `XB_ADDR_KIND1:  rdata_d = kind_q[15:8];
                `XB_ADDR_KIND2:  rdata_d = kind_q[23:16];
                `XB_ADDR_DRV0:   rdata_d = drv_q[7:0];
                `XB_ADDR_DRV1:   rdata_d = drv_q[15:8];
                `XB_ADDR_DRV2:   rdata_d = drv_q[23:16];
                `XB_ADDR_SSMODE: rdata_d = {6'h_00, ssmode_q};
                default:         rdata_d = 8'h_00;
            endcase
        end
    end

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= 8'h_00;
        else
            rdata_o <= rdata_d;
    end

    // which slots are requested
    wire        xb_on    = ctl1_q[`XB_C1_ON]; // R23
    wire        uart_en  = ctl0_q[`XB_C0_UART]; // R22
    wire        spi_en   = ctl0_q[`XB_C0_SPI];
    wire        smb_en   = ctl0_q[`XB_C0_SMB];
    wire [1:0]  arr_f    = ctl1_q[`XB_C1_ARRAY_HI:`XB_C1_ARRAY_LO];
    wire [16:0] want_w;

    assign want_w[`XB_F_TX]        = uart_en; // R06
    assign want_w[`XB_F_RX]        = uart_en;
    assign want_w[`XB_F_SCK]       = spi_en; // R07
    assign want_w[`XB_F_MISO]      = spi_en;
    assign want_w[`XB_F_MOSI]      = spi_en;
    assign want_w[`XB_F_NSS]       = spi_en & ssmode_q[`XB_SS_4WIRE_BIT]; // R07
    assign want_w[`XB_F_SDA]       = smb_en; // R06
    assign want_w[`XB_F_SCL]       = smb_en;
    assign want_w[`XB_F_CMP_SYNC]  = ctl0_q[`XB_C0_CMP_SYNC]; // R21
    assign want_w[`XB_F_CMP_ASYNC] = ctl0_q[`XB_C0_CMP_ASYNC]; // R20
    assign want_w[`XB_F_SYSCLK]    = ctl0_q[`XB_C0_SYSCLK]; // R21
    assign want_w[`XB_F_ARR0]      = (arr_f != 2'h_0); // R24
    assign want_w[`XB_F_ARR1]      = arr_f[1];
    assign want_w[`XB_F_ARR2]      = (arr_f == 2'h_3);
    assign want_w[`XB_F_ARRCLK]    = ctl1_q[`XB_C1_ARRAY_CLK]; // R25
    assign want_w[`XB_F_TMR_A]     = ctl1_q[`XB_C1_TIMER_A];
    assign want_w[`XB_F_TMR_B]     = ctl1_q[`XB_C1_TIMER_B]; // R25

    // uart pins are reserved first, then the chain hands each slot the lowest free pin;
    // purely combinational so placement tracks every settings change at once
    wire [24*(`XB_NFUNC+1)-1:0] taken_w;
    wire [23:0]      uart_pins_w = uart_en ?
                     ((24'h_1 << `XB_UART_TX_PIN) | (24'h_1 << `XB_UART_RX_PIN)) : 24'h_0; // R05
    assign taken_w[23:0] = byp_q | uart_pins_w; // R03 R26

    genvar f;
    generate
        for (f = 0; f < `XB_NFUNC; f = f + 1)
        begin : g_slot
            wire [23:0] free_w = ~taken_w[24*f +: 24];
            wire [23:0] low_w  = free_w & (~free_w + 24'h_1); // R01
            wire        fixed_w = (f == `XB_F_TX) || (f == `XB_F_RX);
            wire [23:0] grab_w = (want_w[f] && !fixed_w) ? low_w : 24'h_0;
            wire [23:0] mine_w = fixed_w ?
                        (want_w[f] ? (24'h_1 << ((f == `XB_F_TX) ? `XB_UART_TX_PIN
                                                                : `XB_UART_RX_PIN))
                                   : 24'h_0)
                        : grab_w; // R05
            assign taken_w[24*(f+1) +: 24] = taken_w[24*f +: 24] | grab_w; // R02
            reg [4:0] idx_r;
            integer   k;
            always @*
            begin
                idx_r = `XB_PIN_NONE;
                for (k = `XB_NPINS - 1; k >= 0; k = k - 1)
                    if (mine_w[k])
                        idx_r = k[4:0];
            end
            assign slot_pin_w[5*f +: 5] = idx_r;
        end
    endgenerate

    // reverse map: per pin, which slot owns it
    genvar p;
    generate
        for (p = 0; p < `XB_NPINS; p = p + 1)
        begin : g_pin
            localparam [4:0] PIN_ID = p;
            reg       owned_r;
            reg [4:0] slot_r;
            integer   j;
            always @*
            begin
                owned_r = 1'b0;
                slot_r  = 5'h_00;
                for (j = 0; j < `XB_NFUNC; j = j + 1)
                    if (slot_pin_w[5*j +: 5] == PIN_ID)
                    begin
                        owned_r = 1'b1;
                        slot_r  = j[4:0];
                    end
            end
            wire digital_w = kind_q[p]; // R12
            wire smb_pin_w = owned_r && xb_on &&
                             (slot_r == `XB_F_SDA || slot_r == `XB_F_SCL);
            wire routed_w  = owned_r && xb_on; // R08
            wire val_w     = routed_w ? func_out_i[slot_r] : port_out_i[p];
            wire drive_w   = routed_w ? func_oe_i[slot_r] : 1'b1;
            wire od_w      = smb_pin_w | ~drv_q[p]; // R14
            // open drain drives only lows; outputs dead with crossbar off or analog
            wire active_w  = xb_on && digital_w && drive_w && (!od_w || !val_w); // R10 R11 R13
            assign pad_out_o[p]     = val_w;
            assign pad_oe_n_o[p]    = ~active_w;
            assign pad_pullup_o[p]  = digital_w && od_w && !ctl1_q[`XB_C1_PULLUP_KILL]
                                      && !(active_w && !val_w); // R15 R16 R13
            assign pad_digital_o[p] = digital_w;
            assign port_in_o[p]     = digital_w & pad_in_i[p]; // R13
        end
    endgenerate

    // route pad levels back to the peripheral that owns each slot
    generate
        for (f = 0; f < `XB_NFUNC; f = f + 1)
        begin : g_back
            wire [4:0] pin_w = slot_pin_w[5*f +: 5];
            assign func_in_o[f] = (xb_on && pin_w != `XB_PIN_NONE)
                                  ? port_in_o[pin_w] : 1'b1;
        end
    endgenerate

endmodule

// file: shared/pin_crossbar_consts.vh
// register offsets, field positions and reset values of the pin crossbar
`ifndef PIN_CROSSBAR_CONSTS_VH
`define PIN_CROSSBAR_CONSTS_VH

`define XB_ADDR_CTL0        8'h_E1
`define XB_ADDR_CTL1        8'h_E2
`define XB_ADDR_BYP0        8'h_D4
`define XB_ADDR_BYP1        8'h_D5
`define XB_ADDR_BYP2        8'h_D6
`define XB_ADDR_KIND0       8'h_F1
`define XB_ADDR_KIND1       8'h_F2
`define XB_ADDR_KIND2       8'h_F3
`define XB_ADDR_DRV0        8'h_A4
`define XB_ADDR_DRV1        8'h_A5
`define XB_ADDR_DRV2        8'h_A6
`define XB_ADDR_SSMODE      8'h_F8

`define XB_CTL0_MASK        8'h_3F
`define XB_CTL1_MASK        8'h_FB
`define XB_CTL0_RESET       8'h_00
`define XB_CTL1_RESET       8'h_00
`define XB_BYP_RESET        8'h_00
`define XB_KIND_RESET       8'h_FF
`define XB_DRV_RESET        8'h_00
`define XB_SSMODE_RESET     2'h_0

`define XB_C0_UART          0
`define XB_C0_SPI           1
`define XB_C0_SMB           2
`define XB_C0_SYSCLK        3
`define XB_C0_CMP_SYNC      4
`define XB_C0_CMP_ASYNC     5
`define XB_C1_ARRAY_LO      0
`define XB_C1_ARRAY_HI      1
`define XB_C1_ARRAY_CLK     3
`define XB_C1_TIMER_A       4
`define XB_C1_TIMER_B       5
`define XB_C1_TIMER_B       5
`define XB_C1_ON            6
`define XB_C1_PULLUP_KILL   7

`define XB_SS_4WIRE_BIT     1
`define XB_UART_TX_PIN      4
`define XB_UART_RX_PIN      5
`define XB_NPINS            24
`define XB_NFUNC            17
`define XB_PIN_NONE         5'h_1F

// function slots in priority order
`define XB_F_TX             0
`define XB_F_RX             1
`define XB_F_SCK            2
`define XB_F_MISO           3
`define XB_F_MOSI           4
`define XB_F_NSS            5
`define XB_F_SDA            6
`define XB_F_SCL            7
`define XB_F_CMP_SYNC       8
`define XB_F_CMP_ASYNC      9
`define XB_F_SYSCLK         10
`define XB_F_ARR0           11
`define XB_F_ARR1           12
`define XB_F_ARR2           13
`define XB_F_ARRCLK         14
`define XB_F_TMR_A          15
`define XB_F_TMR_B          16

`endif

// file: tb/xbar_checker.sv
// port assertions for the pin crossbar
`timescale 1ns/1ns
`include "pin_crossbar_consts.vh"
module xbar_checker
(
    input logic        clk_i,
    input logic        rst_i,
    input logic [7:0]  addr_i,
    input logic [7:0]  wdata_i,
    input logic        wr_i,
    input logic        rd_i,
    input logic [7:0]  rdata_o,
    input logic [23:0] pad_in_i,
    input logic [23:0] port_in_o,
    input logic [16:0] func_in_o,
    input logic [23:0] pad_out_o,
    input logic [23:0] pad_oe_n_o,
    input logic [23:0] pad_pullup_o,
    input logic [23:0] pad_digital_o
);
    logic [7:0]  c0_q;
    logic [7:0]  c1_q;
    logic [23:0] dig_q;
    // shadow copies keep full write data; masking is judged at readback
    always @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            c0_q <= 8'h00;
            c1_q <= 8'h00;
            dig_q <= 24'hFF_FFFF;
        end
        else if (wr_i)
            case (addr_i)
                `XB_ADDR_CTL0: c0_q <= wdata_i;
                `XB_ADDR_CTL1: c1_q <= wdata_i;
                `XB_ADDR_KIND0: dig_q[7:0] <= wdata_i;
                `XB_ADDR_KIND1: dig_q[15:8] <= wdata_i;
                `XB_ADDR_KIND2: dig_q[23:16] <= wdata_i;
                default: ;
            endcase
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd0; rd_i && addr_i == `XB_ADDR_CTL0; endsequence
    sequence s_rd1; rd_i && addr_i == `XB_ADDR_CTL1; endsequence
    property p_rd0; s_rd0 |=> rdata_o == ($past(c0_q) & 8'h3F); endproperty
    property p_rd1; s_rd1 |=> rdata_o == ($past(c1_q) & 8'hFB); endproperty
    property p_off; !c1_q[6] |-> &pad_oe_n_o; endproperty
    property p_off_in; !c1_q[6] |-> &func_in_o; endproperty
    property p_dig; pad_digital_o == dig_q; endproperty
    property p_ana; ((pad_pullup_o | ~pad_oe_n_o | port_in_o) & ~dig_q) == 24'h0; endproperty
    property p_kill; c1_q[7] |-> pad_pullup_o == 24'h0; endproperty
    property p_low; (pad_pullup_o & ~pad_oe_n_o & ~pad_out_o) == 24'h0; endproperty
    property p_uart; c1_q[6] && c0_q[0] && &dig_q[5:4] |-> func_in_o[1:0] == pad_in_i[5:4];
    endproperty
    a_rd0: assert property (p_rd0) else $error("ctl0 read");
    a_rd1: assert property (p_rd1) else $error("ctl1 read");
    a_off: assert property (p_off) else $error("driver on while off");
    a_off_in: assert property (p_off_in) else $error("routed while off");
    a_dig: assert property (p_dig) else $error("receiver enable");
    a_ana: assert property (p_ana) else $error("analog pin active");
    a_kill: assert property (p_kill) else $error("pull-up not killed");
    a_low: assert property (p_low) else $error("pull-up on low pin");
    a_uart: assert property (p_uart) else $error("uart pins");
endmodule
bind priority_pin_crossbar xbar_checker xbar_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pad_in_i(pad_in_i), .port_in_o(port_in_o), .func_in_o(func_in_o),
    .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .pad_pullup_o(pad_pullup_o),
    .pad_digital_o(pad_digital_o));

// file: tb/pad_world.sv
// package pads and board devices around the crossbar
`timescale 1ns/1ns
module pad_world
(
    input  logic        clk_i,
    input  logic [23:0] pad_out_i,
    input  logic [23:0] pad_oe_n_i,
    input  logic [23:0] pad_pullup_i,
    input  logic [23:0] ext_i,
    input  logic [23:0] ext_oe_i,
    output logic [23:0] pad_in_o
);
    logic [23:0] float_q = 24'h5A_5A5A;
    // an unheld pad wanders so no one can lean on a stale level
    always @(posedge clk_i)
        float_q <= ~float_q;
    assign pad_in_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_oe_i & ext_i)
        | (pad_oe_n_i & ~ext_oe_i & (pad_pullup_i | float_q));
endmodule

// file: tb/test_priority_pin_crossbar.sv
// self-checking bench for the pin crossbar
`timescale 1ns/1ns
`include "pin_crossbar_consts.vh"
module test_priority_pin_crossbar;
    logic        clk_i, rst_i, wr_i, rd_i, rd_q, ss4;
    logic [7:0]  addr_i, wdata_i, rdata_o, c0, c1;
    logic [23:0] port_out_i, pad_in_i, port_in_o, pad_out_o, pad_oe_n_o, pad_pullup_o;
    logic [23:0] pad_digital_o, ext, ext_oe, byp, dig;
    logic [16:0] func_out_i, func_oe_i, func_in_o;
    logic [7:0]  expq[$];
    int          error_cnt = 0, num_checks = 0, own[24];
    priority_pin_crossbar priority_pin_crossbar_i (.clk_i(clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .port_out_i(port_out_i), .pad_in_i(pad_in_i), .port_in_o(port_in_o),
        .func_out_i(func_out_i), .func_oe_i(func_oe_i), .func_in_o(func_in_o),
        .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .pad_pullup_o(pad_pullup_o),
        .pad_digital_o(pad_digital_o));
    pad_world pad_world_i (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pad_pullup_i(pad_pullup_o), .ext_i(ext), .ext_oe_i(ext_oe), .pad_in_o(pad_in_i));
    initial
    begin
        clk_i = 0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic cmp(input logic [23:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        rd_q <= rd_i;
        if (rd_q)
            cmp({16'h0, rdata_o}, {16'h0, expq.pop_front()});
    end
    task bus(input logic w, r, input logic [7:0] a, d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask
    task wr(input logic [7:0] a, d); bus(1, 0, a, d); endtask
    task rd(input logic [7:0] a, e); expq.push_back(e); bus(0, 1, a, 8'h00); endtask
    task cfg(input logic [7:0] kd, dv);
        for (logic [7:0] i = 0; i < 3; i++) wr(`XB_ADDR_KIND0 + i, i == 0 ? kd : 8'hFF);
        for (logic [7:0] i = 0; i < 3; i++) wr(`XB_ADDR_DRV0 + i, dv);
        for (logic [7:0] i = 0; i < 3; i++) wr(`XB_ADDR_BYP0 + i, byp[i*8 +: 8]);
        wr(`XB_ADDR_SSMODE, {6'h0, ss4, 1'b0});
        wr(`XB_ADDR_CTL0, c0);
        wr(`XB_ADDR_CTL1, c1);
        bus(0, 0, 8'h00, 8'h00);
        #1;
    endtask
    // expected owner slot of every pin, -1 for a plain port pin
    function automatic void place;
        logic [16:0] en;
        logic [23:0] tk;
        int          p;
        en = {c1[5], c1[4], c1[3], &c1[1:0], c1[1], |c1[1:0], c0[3], c0[5], c0[4], {2{c0[2]}},
              c0[1] & ss4, {3{c0[1]}}, {2{c0[0]}}};
        tk = byp;
        p = 0;
        foreach (own[i]) own[i] = -1;
        if (en[0])
        begin
            own[4] = 0;
            own[5] = 1;
            tk[5:4] = 2'b11;
        end
        for (int s = 2; s < 17; s++)
            if (en[s])
            begin
                while (p < 24 && tk[p]) p++;
                if (p < 24)
                begin
                    own[p] = s;
                    tk[p] = 1'b1;
                end
            end
    endfunction
    task check_route;
        logic [23:0] en_n, eout;
        logic [16:0] ein;
        int          s;
        place();
        ein = 17'h1_FFFF;
        for (int n = 0; n < 24; n++)
        begin
            s = own[n];
            en_n[n] = s < 0 ? 1'b0 : ~func_oe_i[s] | (s == 6 || s == 7) & func_out_i[s];
            eout[n] = s < 0 ? port_out_i[n] : func_out_i[s];
            if (s >= 0) ein[s] = pad_in_i[n];
        end
        cmp(pad_oe_n_o, en_n);
        cmp(pad_out_o & ~en_n, eout & ~en_n);
        cmp({7'h0, func_in_o}, {7'h0, ein});
    endtask
    initial
    begin
        void'($urandom(32'hBF56_C3C8));
        rst_i = 1'b1;
        {wr_i, rd_i, addr_i, wdata_i, port_out_i, func_out_i} = '0;
        {func_oe_i, ext, ext_oe, byp, ss4} = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        rd(`XB_ADDR_CTL0, 8'h00);
        rd(`XB_ADDR_KIND0, 8'hFF);
        rd(`XB_ADDR_DRV0, 8'h00);
        rd(8'h00, 8'h00);
        wr(`XB_ADDR_CTL0, 8'hFF);
        wr(`XB_ADDR_CTL1, 8'hBF);
        rd(`XB_ADDR_CTL0, 8'h3F);
        rd(`XB_ADDR_CTL1, 8'hBB);
        bus(0, 0, 8'h00, 8'h00);
        #1 cmp(pad_oe_n_o, 24'hFF_FFFF);
        cmp({7'h0, func_in_o}, 24'h01_FFFF);
        @(posedge clk_i);
        port_out_i <= 24'($urandom);
        {c0, c1} = 16'h0040;
        byp = 24'h00_00F0;
        cfg(8'h0F, 8'h00);
        dig = 24'hFF_FF0F;
        cmp(pad_pullup_o, dig & port_out_i);
        cmp(pad_oe_n_o, ~dig | port_out_i);
        cmp(port_in_o, dig & pad_in_i);
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clk_i);
            c0 = k ? 8'($urandom) : 8'h07;
            c1 = k ? 8'($urandom) | 8'h40 : 8'h40;
            byp = k ? 24'($urandom) : 24'h00_0044;
            ss4 = k ? 1'($urandom) : 1'b1;
            {port_out_i, ext, ext_oe} <= {24'($urandom), 24'($urandom), 24'($urandom)};
            func_out_i <= 17'($urandom);
            func_oe_i <= 17'($urandom) & 17'h0_3FFD;
            cfg(8'hFF, 8'hFF);
            check_route();
        end
        final_report();
    end
    initial
    begin
        #200_000;
        error_cnt++;
        final_report();
    end
endmodule
